// File: rtl/nvcfg_pkg.sv
package nvcfg_pkg;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;            // 40 MHz ref clock
   localparam int PROG_TIME_NS = 1000000;        // Program cycle time, plain default
   // Longest time rounds down
   localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
   // -------------------------------------------------------------
   // Serial bus selection
   // -------------------------------------------------------------
   localparam logic [3:0] ADDR_FIXED = 4'h9;     // Fixed upper address bits
   localparam logic [7:0] PTR_NVCFG = 8'h11;     // Pointer of the register
   // -------------------------------------------------------------
   // Register layout
   // -------------------------------------------------------------
   localparam logic [15:0] NV_FACTORY = 16'h0000; // Factory contents
   localparam logic [15:0] NV_WR_MASK = 16'h7f06; // Implemented bits
   localparam int RES_LSB = 13;                  // default_resolution_sel
   localparam int FQ_LSB = 11;                   // default_fault_queue_sel
   localparam int POL_BIT = 10;                  // default_alarm_polarity
   localparam int MODE_BIT = 9;                  // default_alarm_mode
   localparam int SD_BIT = 8;                    // default_shutdown
   localparam int LOCKDN_BIT = 2;                // permanent_lockdown
   localparam int LOCK_BIT = 1;                  // reversible_lock
   localparam int VOL_LSB = 8;                   // Copied byte, low bit
   localparam int BYTE_BITS = 8;                 // Bits per bus byte
endpackage

// File: rtl/nvcfg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pins; idles high like the bus lines
module nvcfg_sync #(
   parameter int W = 2
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff; // First stage, read by second stage only

   if (W < 1) begin : g_chk
      $error("nvcfg_sync: W must be at least 1");
   end

   // -------------------------------------------------------------
   // Two flops in series
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_ff <= '1;
         q_o <= '1;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// File: rtl/nvcfg_prog.sv
`timescale 1ns/1ps
`default_nettype none
// Nonvolatile cells plus the self-timed program cycle
module nvcfg_prog #(
   parameter int PROG_CYCLES = nvcfg_pkg::PROG_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [15:0] data_i,
   output logic busy_o,
   output logic [15:0] nv_o
);
   localparam int CW = $clog2(PROG_CYCLES + 1);
   logic [CW-1:0] cnt_ff;     // Cycles spent programming
   logic [15:0] pend_ff;      // Word being programmed
   logic [15:0] cells_ff = nvcfg_pkg::NV_FACTORY; // Stored word, factory value at power-up

   if (PROG_CYCLES < 1) begin : g_chk
      $error("nvcfg_prog: PROG_CYCLES must be at least 1");
   end

   // -------------------------------------------------------------
   // Storage: no reset, so contents live through device reset
   // -------------------------------------------------------------
   assign nv_o = cells_ff;
   always_ff @(posedge ref_clk_i) begin
      // Commit only at the end of a full cycle
      if (!rst_i && busy_o && cnt_ff == CW'(PROG_CYCLES - 1)) begin
         cells_ff <= pend_ff;
      end
   end

   // -------------------------------------------------------------
   // Program timer; a reset mid-cycle drops the word, old data stays
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         cnt_ff <= '0;
         pend_ff <= '0;
      end else if (!busy_o) begin
         if (start_i) begin
            busy_o <= 1'b1;
            pend_ff <= data_i;
            cnt_ff <= '0;
         end
      end else if (cnt_ff == CW'(PROG_CYCLES - 1)) begin
         busy_o <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   a_prog_length: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      busy_o |-> cnt_ff < CW'(PROG_CYCLES))
      else $error("program cycle overran");
   a_nv_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !$past(busy_o) |-> $stable(nv_o))
      else $error("cells changed outside a program cycle");
   a_start_busy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      start_i && !busy_o |=> busy_o && pend_ff == $past(data_i))
      else $error("accepted start did not raise busy");
endmodule
`default_nettype wire

// File: rtl/nvcfg_top.sv
// Overview of operation
// - Sixteen-bit register survives power loss, reset
// - Reset copies bits 15:8 into volatile config
// - Bit 15, 7:3, 0 read zero
// - Resolution default codes select 9..12 bits
// - Fault queue default codes need 1,2,4,6
// - Bit 10 sets default alarm polarity
// - Bit 9 selects comparator or interrupt mode
// - Bit 8 starts device in shutdown
// - Lockdown bit freezes registers forever
// - Reversible lock bit blocks modification
// - Address and pointer 11h are acknowledged
// - Two data bytes; further bytes ignored
// - Short data before stop or restart discarded
// - Stop after valid write starts programming
// - Busy status shown while programming
// - Repeated start aborts programming, keeps contents
// - No programming when busy or locked down; while locked, only clearing the lock programs
// - Locked writes still acknowledged fully
// - Busy writes: data bytes not acknowledged
//
`timescale 1ns/1ps
`default_nettype none
module nvcfg_top #(
   parameter int PROG_CYCLES = nvcfg_pkg::PROG_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [2:0] slave_addr_select_pins_i,
   output logic [1:0] resolution_sel_o,
   output logic [1:0] fault_queue_sel_o,
   output logic alarm_polarity_o,
   output logic alarm_mode_o,
   output logic shutdown_o,
   output logic nv_store_busy_o
);
   // The timer needs at least one cycle to count
   if (PROG_CYCLES < 1) begin : g_chk
      $error("nvcfg_top: PROG_CYCLES must be at least 1");
   end

   // -------------------------------------------------------------
   // Types and signals
   // -------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, // Bus free or not addressed
      ST_ADDR = 6'h02, // Taking the address byte
      ST_PTR = 6'h04,  // Taking the pointer byte
      ST_WDAT = 6'h08, // Taking data bytes
      ST_RDAT = 6'h10, // Sending data bytes
      ST_SKIP = 6'h20  // Ignoring until stop or start
   } nvcfg_state_e;

   nvcfg_state_e state_ff;        // Transfer phase
   logic scl_s, sda_s;            // Synchronised lines
   logic [2:0] pins_s;            // Synchronised address pins
   logic scl_d_ff, sda_d_ff;      // Previous samples for edges
   logic scl_rise, scl_fall;      // Clock edges seen
   logic start_det, stop_det;     // Bus conditions
   logic [3:0] bit_cnt_ff;        // Bits of current byte
   logic [7:0] shift_ff;          // Received byte
   logic ack_ph_ff;               // Inside the ninth clock
   logic [1:0] byte_cnt_ff;       // Data bytes taken, saturating
   logic [15:0] wdata_ff;         // Collected write word
   logic [7:0] ptr_ff;            // Pointer value
   logic [15:0] tx_ff;            // Outgoing read word
   logic ptr_hit;                 // Pointer selects this register
   logic byte_done;               // Eighth bit just ended
   logic [15:0] nv_q;             // Stored contents
   logic [15:0] nv_rd;            // Contents as read
   logic prog_busy;               // Program cycle running
   logic prog_go_ff;              // Start pulse to the cells
   logic [15:0] prog_data_ff;     // Word to program
   logic [7:0] vol_ff;            // Volatile configuration copy

   // -------------------------------------------------------------
   // Pin sampling: scl, sda and pins cross into ref_clk_i
   // -------------------------------------------------------------
   nvcfg_sync #(
      .W(5)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i({scl_i, sda_i, slave_addr_select_pins_i}),
      .q_o({scl_s, sda_s, pins_s})
   );

   // Edge history from the synchronised lines only
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   // Start and stop are sda moving while scl stays high
   assign scl_rise = scl_s & ~scl_d_ff;
   assign scl_fall = ~scl_s & scl_d_ff;
   assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
   assign byte_done = scl_fall & ~ack_ph_ff &
      (bit_cnt_ff == 4'(nvcfg_pkg::BYTE_BITS));
   assign ptr_hit = (ptr_ff == nvcfg_pkg::PTR_NVCFG);
   assign nv_rd = nv_q & nvcfg_pkg::NV_WR_MASK;

   // -------------------------------------------------------------
   // Cells and program timer
   // -------------------------------------------------------------
   nvcfg_prog #(
      .PROG_CYCLES(PROG_CYCLES)
   ) u_prog (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .start_i(prog_go_ff),
      .data_i(prog_data_ff),
      .busy_o(prog_busy),
      .nv_o(nv_q)
   );

   // -------------------------------------------------------------
   // Bit timing: sample on scl rise, count bits, track ack slot
   // -------------------------------------------------------------
   // Nothing shifts in the ninth clock, so an ack never lands in a byte
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || start_det || stop_det) begin
         bit_cnt_ff <= '0;
         ack_ph_ff <= 1'b0;
         shift_ff <= '0;
      end else if (scl_rise && !ack_ph_ff) begin
         shift_ff <= {shift_ff[6:0], sda_s};
         bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end else if (byte_done) begin
         ack_ph_ff <= 1'b1;
      end else if (scl_fall && ack_ph_ff) begin
         ack_ph_ff <= 1'b0;
         bit_cnt_ff <= '0;
      end
   end

   // -------------------------------------------------------------
   // Transfer phases, decided at the end of each byte
   // -------------------------------------------------------------
   // A foreign address parks in idle until the next start
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || stop_det) begin
         state_ff <= ST_IDLE;
      end else if (start_det) begin
         state_ff <= ST_ADDR;
      end else if (byte_done) begin
         unique case (state_ff)
            ST_ADDR: begin
               if (shift_ff[7:1] != {nvcfg_pkg::ADDR_FIXED, pins_s}) begin
                  state_ff <= ST_IDLE;
               end else if (shift_ff[0]) begin
                  state_ff <= ST_RDAT;
               end else begin
                  state_ff <= ST_PTR;
               end
            end
            ST_PTR: begin
               state_ff <= ST_WDAT;
            end
            default: begin
               state_ff <= state_ff;
            end
         endcase
      end else if (state_ff == ST_RDAT && ack_ph_ff && scl_rise && sda_s) begin
         // Master refused the byte: stop sending
         state_ff <= ST_SKIP;
      end
   end

   // Pointer is kept across transfers so reads may rely on it
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ptr_ff <= '0;
      end else if (byte_done && state_ff == ST_PTR) begin
         ptr_ff <= shift_ff;
      end
   end

   // -------------------------------------------------------------
   // Write collection: two bytes high first, extras dropped
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || start_det) begin
         byte_cnt_ff <= '0;
         wdata_ff <= '0;
      end else if (byte_done && state_ff == ST_WDAT && ptr_hit && !prog_busy) begin
         if (byte_cnt_ff == 2'h0) begin
            wdata_ff[15:8] <= shift_ff;
            byte_cnt_ff <= 2'h1;
         end else if (byte_cnt_ff == 2'h1) begin
            wdata_ff[7:0] <= shift_ff;
            byte_cnt_ff <= 2'h2;
         end
         // Third and later bytes leave the word alone
      end
   end

   // -------------------------------------------------------------
   // Program request, issued only on a stop after a full word
   // -------------------------------------------------------------
   // Busy and both locks are judged again at the stop itself
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         prog_go_ff <= 1'b0;
         prog_data_ff <= '0;
      end else begin
         prog_go_ff <= 1'b0;
         if (stop_det && state_ff == ST_WDAT && ptr_hit && byte_cnt_ff == 2'h2 &&
               !prog_busy && !nv_q[nvcfg_pkg::LOCKDN_BIT]) begin
            if (!nv_q[nvcfg_pkg::LOCK_BIT]) begin
               prog_go_ff <= 1'b1;
               prog_data_ff <= wdata_ff & nvcfg_pkg::NV_WR_MASK;
            end else if (!wdata_ff[nvcfg_pkg::LOCK_BIT]) begin
               // While locked only the lock bit itself may be cleared
               prog_go_ff <= 1'b1;
               prog_data_ff <= nv_rd & ~(16'h0001 << nvcfg_pkg::LOCK_BIT);
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Open-drain data line: ack slots and read bits
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || start_det || stop_det) begin
         sda_oe_o <= 1'b0;
         tx_ff <= '0;
      end else if (byte_done) begin
         tx_ff <= {tx_ff[14:0], 1'b0};
         unique case (state_ff)
            ST_ADDR: begin
               sda_oe_o <= (shift_ff[7:1] == {nvcfg_pkg::ADDR_FIXED, pins_s});
               // Other pointers read as zero from this block
               tx_ff <= ptr_hit ? nv_rd : '0;
            end
            ST_PTR: begin
               sda_oe_o <= 1'b1;
            end
            ST_WDAT: begin
               // Locked writes are acked, busy ones are not
               sda_oe_o <= !(ptr_hit && prog_busy);
            end
            default: begin
               // Read: release for master ack; skip: stay quiet
               sda_oe_o <= 1'b0;
            end
         endcase
      end else if (scl_fall && ack_ph_ff) begin
         // Ack slot over: drive first read bit or release
         sda_oe_o <= (state_ff == ST_RDAT) && !tx_ff[15];
      end else if (scl_fall && state_ff == ST_RDAT) begin
         tx_ff <= {tx_ff[14:0], 1'b0};
         sda_oe_o <= !tx_ff[14];
      end
   end

   // Open drain: a high level comes from the pull-up, never from here
   // Only ever pulls low
   always_ff @(posedge ref_clk_i) begin
      sda_o <= 1'b0;
   end

   // -------------------------------------------------------------
   // Volatile configuration: reloaded from the cells on reset
   // -------------------------------------------------------------
   // Never written outside reset: the copy is the running setup
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         vol_ff <= nv_q[15:nvcfg_pkg::VOL_LSB];
      end
   end

   assign resolution_sel_o = vol_ff[nvcfg_pkg::RES_LSB - nvcfg_pkg::VOL_LSB +: 2];
   assign fault_queue_sel_o = vol_ff[nvcfg_pkg::FQ_LSB - nvcfg_pkg::VOL_LSB +: 2];
   assign alarm_polarity_o = vol_ff[nvcfg_pkg::POL_BIT - nvcfg_pkg::VOL_LSB];
   assign alarm_mode_o = vol_ff[nvcfg_pkg::MODE_BIT - nvcfg_pkg::VOL_LSB];
   assign shutdown_o = vol_ff[nvcfg_pkg::SD_BIT - nvcfg_pkg::VOL_LSB];

   // Busy status follows the timer one cycle later
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         nv_store_busy_o <= 1'b0;
      end else begin
         nv_store_busy_o <= prog_busy;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   // All but the reload check are idle while reset is held
   a_vol_reload: assert property (@(posedge ref_clk_i)
      rst_i |=> vol_ff == $past(nv_q[15:8]))
      else $error("volatile copy differs from cells");
   a_busy_nack: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      byte_done && state_ff == ST_WDAT && ptr_hit && prog_busy |=> !sda_oe_o)
      else $error("data byte acked while busy");
   a_lock_ack: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      byte_done && state_ff == ST_WDAT && !prog_busy |=> sda_oe_o [*2])
      else $error("data byte not acked");
   a_short_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      stop_det && byte_cnt_ff != 2'h2 |=> !prog_go_ff)
      else $error("short write started programming");
   a_restart_abort: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      start_det |=> !prog_go_ff)
      else $error("repeated start started programming");
   a_lockdown_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      nv_q[nvcfg_pkg::LOCKDN_BIT] |-> !prog_go_ff ##1 $stable(nv_q))
      else $error("locked-down register modified");
   a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      prog_go_ff |-> (prog_data_ff & ~nvcfg_pkg::NV_WR_MASK) == 16'h0000)
      else $error("reserved bit programmed");
   a_busy_refuse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      prog_busy |=> !prog_go_ff)
      else $error("program requested while busy");
   a_extra_ignored: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      byte_done && byte_cnt_ff == 2'h2 |=> $stable(wdata_ff))
      else $error("extra byte changed write word");
   a_busy_status: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      prog_go_ff && !prog_busy |=> ##1 nv_store_busy_o)
      else $error("busy status not shown");
   a_addr_refuse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      byte_done && state_ff == ST_ADDR &&
      shift_ff[7:1] != {nvcfg_pkg::ADDR_FIXED, pins_s} |=> !sda_oe_o)
      else $error("foreign address acknowledged");
   a_stop_prog: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      stop_det && state_ff == ST_WDAT && ptr_hit && byte_cnt_ff == 2'h2 && !prog_busy &&
      nv_q[nvcfg_pkg::LOCKDN_BIT:nvcfg_pkg::LOCK_BIT] == 2'h0 |=> prog_go_ff)
      else $error("valid write did not start programming");
endmodule
`default_nettype wire

// File: dv/nvcfg_master.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Bus master model: drives scl, pulls sda low, samples the wire
// ---------------------------------------------------------------
module nvcfg_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   // Idle with both lines high; scl stands still between frames
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // Every change lands on a falling ref edge, clear of the sampling edge
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Data moves one cycle after scl falls so no false start or stop is seen
   task automatic bit_io(input logic b, output logic s);
      wait_n(1);
      sda_pull_o = ~b;
      wait_n(3);
      scl_o = 1'b1;
      wait_n(4);
      s = sda_i;
      scl_o = 1'b0;
   endtask
   // Start from idle: sda falls while scl is high
   task automatic start();
      wait_n(1);
      sda_pull_o = 1'b1;
      wait_n(4);
      scl_o = 1'b0;
   endtask
   // Repeated start in mid-frame
   task automatic rstart();
      wait_n(1);
      sda_pull_o = 1'b0;
      wait_n(3);
      scl_o = 1'b1;
      wait_n(4);
      sda_pull_o = 1'b1;
      wait_n(4);
      scl_o = 1'b0;
   endtask
   // Stop: sda rises while scl is high, then the bus idles
   task automatic stop();
      wait_n(1);
      sda_pull_o = 1'b1;
      wait_n(3);
      scl_o = 1'b1;
      wait_n(4);
      sda_pull_o = 1'b0;
      wait_n(4);
   endtask
   // Byte out, high bit first; ack is the device pulling bit nine low
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // Byte in; the master releases sda for all eight bits
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(~ack, s);
   endtask
endmodule
`default_nettype wire

// File: dv/test_nvcfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_nvcfg_top;
   // ---------------------------------------------------------------
   // Signals and model state
   // ---------------------------------------------------------------
   localparam int PROG = 400; // Long enough to overlap a second write
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] pins = 3'h4;
   logic scl, sda_pull, sda_o, sda_oe_o, pol, mode, sd, busy;
   logic [1:0] res, fq;
   wire sda_w;
   int fails = 0;
   int checked = 0;
   int progs = 0; // Busy rises seen
   int exp_progs = 0; // Programs the model expects
   logic [15:0] nv_exp = 16'h0000; // Model of the stored value
   logic [7:0] seed = 8'h54;
   always #12.5 ref_clk_i = ~ref_clk_i;
   // Open-drain wire with pull-up: low if either party pulls
   assign sda_w = (sda_oe_o ? sda_o : 1'b1) & ~sda_pull;
   always @(posedge busy) progs++;
   nvcfg_top #(.PROG_CYCLES(PROG)) i_nvcfg_top (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .slave_addr_select_pins_i(pins),
      .resolution_sel_o(res), .fault_queue_sel_o(fq), .alarm_polarity_o(pol),
      .alarm_mode_o(mode), .shutdown_o(sd), .nv_store_busy_o(busy));
   nvcfg_master i_nvcfg_master (
      .clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] lfsr();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Model of a completed write; locked writes may only clear the lock
   task automatic apply(input logic [15:0] d);
      if (!nv_exp[2] && !nv_exp[1]) begin
         nv_exp = d & nvcfg_pkg::NV_WR_MASK;
         exp_progs++;
      end else if (!nv_exp[2] && !d[1]) begin
         nv_exp[1] = 1'b0;
         exp_progs++;
      end
   endtask
   // Write frame with n data bytes; bytes past two are random filler
   task automatic wr_nv(input logic [15:0] d, input int n, input logic rs,
                        output logic [15:0] a);
      logic k;
      a = 16'h0000;
      i_nvcfg_master.start();
      i_nvcfg_master.wr_byte({nvcfg_pkg::ADDR_FIXED, pins, 1'b0}, k);
      a[0] = k;
      i_nvcfg_master.wr_byte(nvcfg_pkg::PTR_NVCFG, k);
      a[1] = k;
      for (int i = 0; i < n; i++) begin
         i_nvcfg_master.wr_byte(i == 0 ? d[15:8] : i == 1 ? d[7:0] : lfsr(), k);
         a[i + 2] = k;
      end
      if (rs) begin
         i_nvcfg_master.rstart();
      end
      i_nvcfg_master.stop();
   endtask
   // Pointer set, repeated start, two bytes back high first
   task automatic rd_nv(output logic [15:0] v);
      logic k;
      i_nvcfg_master.start();
      i_nvcfg_master.wr_byte({nvcfg_pkg::ADDR_FIXED, pins, 1'b0}, k);
      i_nvcfg_master.wr_byte(nvcfg_pkg::PTR_NVCFG, k);
      i_nvcfg_master.rstart();
      i_nvcfg_master.wr_byte({nvcfg_pkg::ADDR_FIXED, pins, 1'b1}, k);
      i_nvcfg_master.rd_byte(1'b1, v[15:8]);
      i_nvcfg_master.rd_byte(1'b0, v[7:0]);
      i_nvcfg_master.stop();
   endtask
   // Busy shows a few cycles after stop, so wait before polling it
   task automatic settle();
      int n;
      n = 0;
      repeat (8) @(negedge ref_clk_i);
      while (busy !== 1'b0 && n < PROG + 50) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("busy ends", {15'h0000, busy}, 16'h0000);
      chk("programs", 16'(progs), 16'(exp_progs));
   endtask
   task automatic rst_chk();
      rst_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      chk("volatile", {9'h000, res, fq, pol, mode, sd}, {9'h000, nv_exp[14:8]});
   endtask
   // Full write, acks, model update, read-back
   task automatic wr_chk(input logic [15:0] d, input int n, input logic rs);
      logic [15:0] a;
      logic [15:0] v;
      wr_nv(d, n, rs, a);
      chk("acks", a, 16'((1 << (n + 2)) - 1));
      if (n >= 2 && !rs) begin
         apply(d);
      end
      settle();
      rd_nv(v);
      chk("stored", v, nv_exp);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] d;
      logic [15:0] a;
      logic [15:0] v;
      logic k;
      repeat (12) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      rd_nv(v);
      chk("factory", v, 16'h0000);
      rst_chk();
      $display("test factory done");
      // Every field code, reserved bits set at random to prove masking
      for (int i = 0; i < 4; i++) begin
         d = {lfsr(), lfsr()} & 16'h87f9;
         wr_chk(d | {1'b0, 2'(i), 2'(i), 11'h000}, 2, 1'b0);
         rst_chk();
      end
      $display("test random writes done");
      wr_chk(~nv_exp & 16'hfff9, 1, 1'b0);
      wr_chk(~nv_exp & 16'hfff9, 2, 1'b1);
      wr_chk({lfsr(), lfsr()} & 16'hfff9, 3, 1'b0);
      $display("test short restart extra done");
      // Second write lands while the first still programs
      d = {lfsr(), lfsr()} & 16'hfff9;
      wr_nv(d, 2, 1'b0, a);
      apply(d);
      wr_nv(~d & 16'hfff9, 2, 1'b0, a);
      chk("busy acks", a, 16'h0003);
      settle();
      rd_nv(v);
      chk("busy stored", v, nv_exp);
      $display("test busy done");
      i_nvcfg_master.start();
      i_nvcfg_master.wr_byte({nvcfg_pkg::ADDR_FIXED, ~pins, 1'b0}, k);
      i_nvcfg_master.stop();
      chk("wrong addr", {15'h0000, k}, 16'h0000);
      $display("test address done");
      // Lock, refused write, unlock, permanent lockdown, then a refused write
      wr_chk(({lfsr(), lfsr()} & 16'hfffb) | 16'h0002, 2, 1'b0);
      wr_chk({lfsr(), lfsr()} | 16'h0002, 2, 1'b0);
      wr_chk({lfsr(), lfsr()} & 16'hfffd, 2, 1'b0);
      wr_chk((nv_exp & 16'hfffd) | 16'h0004, 2, 1'b0);
      wr_chk({lfsr(), lfsr()} & 16'hfff9, 2, 1'b0);
      rst_chk();
      $display("test locks done");
      results();
   end
   // Watchdog: 60000 cycles, several times what the scenarios need
   initial begin
      #1500000;
      fails++;
      results();
   end
endmodule
`default_nettype wire
